/* File: hdl/emb_pkg.sv */
// Purpose: Shared constants and types of the external memory bus pin control.
// Assumes: One clock, the core instruction clock, at 100 MHz.
// Notes:   Pin vector layout is D 7:0, E 15:8, H 19:16, J 27:20.
//
// Function
// - Without offset, drive full program counter.
// - Offset enabled: subtract on-chip size from address.
// - 20-bit width: byte bit extends to 2 Mbyte.
// - Provide active-low upper and lower byte selects.
// - 8-bit data: AD7:0 shared, upper address only; the code drives write data on AD15:8 and floats them during reads.
// - 16-bit data: AD15:0 shared, A19:16 address.
// - Wait states add fixed delay after table ops.
// - Pull-ups for D, E, J ports only.
// - Every reset clears all three pull-up enables.
// - Microcontroller mode: bus off, control writes ignored.
// - External access takes pins despite release bit.
// - Internal only: release bit picks bus or port.
// - Release set externally waits for internal branch.
// - Idle bus: tri-state data, fixed control levels.
// - Idle tri-state only lines of address width.
// - Bus beats all other pin users.
// - 16-bit data: write-mode field picks configuration.
// - Address strobe, then output enable reads word.
// - Chip select low on access, high in Sleep.
// - Byte write: latch on both halves, strobe by LSB.
// - Wait field inverse: 11 none, 00 three.
// - Write mode: 1x word, 01 select, 00 byte.
// - Release clear keeps bus always on.
// - Data width bit set selects 16 bits.

package emb_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int TCY_NS = 10;
    localparam int TCY_CYC = (TCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Output enable stays low this long; four cycles let read data clear
    // the three-flop input path before the second and third flops agree.
    localparam int RD_CYC = 4;
    localparam int WR_CYC = 1;

    // ****************************************************************
    // Pin vector layout and field positions
    // ****************************************************************
    localparam int PIN_D_LSB = 0;
    localparam int PIN_E_LSB = 8;
    localparam int PIN_H_LSB = 16;
    localparam int PIN_J_LSB = 20;
    localparam int J_ALE = 0;
    localparam int J_OE = 1;
    localparam int J_WRL = 2;
    localparam int J_WRH = 3;
    localparam int J_BA0 = 4;
    localparam int J_CE = 5;
    localparam int J_LB = 6;
    localparam int J_UB = 7;
    localparam logic [7:0] J_IDLE = 8'hee;
    localparam int PAD_PU_LSB = 5;
    localparam logic [1:0] ABW_20 = 2'h0;
    localparam logic [1:0] ABW_16 = 2'h1;
    localparam logic [1:0] ABW_12 = 2'h2;
    localparam logic [1:0] ABW_MCU = 2'h3;
    localparam logic [1:0] WM_BYTE_WRITE = 2'h0;
    localparam logic [1:0] WM_BYTE_SELECT = 2'h1;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {K_FETCH, K_TBLRD, K_TABLE_WRITE_INSTR} emb_kind_t;
    typedef enum logic [2:0] {S_IDLE, S_ALE, S_RD, S_RD2, S_WR, S_WAIT}
        emb_phase_t;

    typedef struct packed {
        logic bus_release;
        logic [1:0] wait_field;
        logic [1:0] write_mode_field;
    } emb_ctl_t;

    typedef struct packed {
        emb_kind_t kind;
        logic [19:0] word;
        logic byte_address_bit;
        logic [7:0] table_latch;
    } emb_req_t;

    typedef struct packed {
        emb_phase_t phase;
        logic [2:0] cnt;
        emb_ctl_t ctl;
        logic release_eff;
        logic [2:0] pad;
        emb_req_t req;
        logic [7:0] hold;
        logic [15:0] s1;
        logic [15:0] s2;
        logic [15:0] s3;
        logic [15:0] rdata;
        logic done;
        logic [27:0] own;
        logic [27:0] pin_out;
        logic [27:0] pin_oe;
    } emb_state_t;

    localparam emb_state_t EMB_ST_RESET = '0;

endpackage : emb_pkg

/* File: hdl/emb_bus.sv */
// Purpose: External memory bus sequencer and pin ownership for the core.
// Assumes: Requests and configuration come from logic on the same clock.
// Notes:   One instruction cycle equals one clock cycle here.

`timescale 1ns/1ps

module emb_bus
    import emb_pkg::*;
#(
    parameter logic [20:0] ONCHIP_SIZE = 21'h020000
) (
    // Clock and reset.
    input wire logic CLOCK_I,
    input wire logic RST_I,
    // Configuration straps.
    input wire logic [1:0] ADDR_WIDTH_SEL_I,
    input wire logic DATA_WIDTH_SEL_I,
    input wire logic ADDRESS_OFFSET_ENABLE_I,
    input wire logic WAIT_EN_I,
    // Core state.
    input wire logic EXEC_INTERNAL_I,
    input wire logic SLEEP_I,
    // Bus control and pad configuration writes.
    input wire logic CTL_WR_I,
    input wire logic [7:0] CTL_DATA_I,
    input wire logic PAD_WR_I,
    input wire logic [7:0] PAD_DATA_I,
    // Access request.
    input wire logic REQ_VALID_I,
    input wire emb_kind_t REQ_KIND_I,
    input wire logic [20:0] REQ_ADDR_I,
    input wire logic [7:0] REQ_DATA_I,
    // Port function values that the bus may override.
    input wire logic [27:0] PORT_OUT_I,
    input wire logic [27:0] PORT_OE_I,
    // Pin levels.
    input wire logic [15:0] PIN_AD_I,
    // Pins.
    output logic [27:0] PIN_OUT_O,
    output logic [27:0] PIN_OE_O,
    output logic [27:0] BUS_OWN_O,
    output logic PORT_D_PULLUP_EN_O,
    output logic PORT_E_PULLUP_EN_O,
    output logic PORT_J_PULLUP_EN_O,
    // Status.
    output logic [7:0] CTL_RD_O,
    output logic BUSY_O,
    output logic DONE_O,
    output logic [15:0] RDATA_O
);

    // ****************************************************************
    // State
    // ****************************************************************
    emb_state_t st_r;
    emb_state_t st_nxt;
    logic [7:0] ctl_rd_r;
    logic busy_r;

    // ****************************************************************
    // Next state
    // ****************************************************************

    // Sequencer, configuration and pin multiplexing in one pass.
    always_comb begin
        logic mcu, fin, wide, is_rd, is_wr, act, bad_oe, ba_oe;
        logic [20:0] badr;
        logic [1:0] waits;
        logic [15:0] bad;
        logic [3:0] ba;
        logic [7:0] bj, own_e;
        logic [27:0] bus_o, bus_oe;
        mcu = (ADDR_WIDTH_SEL_I == ABW_MCU);
        fin = 1'b0;
        wide = DATA_WIDTH_SEL_I;
        is_rd = 1'b0;
        is_wr = 1'b0;
        act = 1'b0;
        badr = '0;
        waits = 2'h0;
        bad = '0;
        bad_oe = 1'b0;
        ba = '0;
        ba_oe = 1'b0;
        bj = J_IDLE;
        own_e = 8'h00;
        bus_o = '0;
        bus_oe = '0;
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        st_nxt.s1 = PIN_AD_I;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;

        // Control writes are refused while the microcontroller mode strap is selected.
        if (CTL_WR_I && !mcu) begin
            st_nxt.ctl.bus_release = CTL_DATA_I[7];
            st_nxt.ctl.wait_field = CTL_DATA_I[5:4];
            st_nxt.ctl.write_mode_field = CTL_DATA_I[1:0];
        end
        if (PAD_WR_I) begin
            st_nxt.pad = PAD_DATA_I[7:PAD_PU_LSB];
        end

        // Setting release only lands once code runs from inside, so the
        // pins never leave mid-fetch; clearing acts at once.
        if (!st_nxt.ctl.bus_release) begin
            st_nxt.release_eff = 1'b0;
        end else if (EXEC_INTERNAL_I) begin
            st_nxt.release_eff = 1'b1;
        end

        // Offset shifting hides the on-chip part of the address map.
        if (ADDRESS_OFFSET_ENABLE_I) begin
            badr = REQ_ADDR_I - ONCHIP_SIZE;
        end else begin
            badr = REQ_ADDR_I;
        end
        waits = ~st_r.ctl.wait_field;

        // Sleep freezes the sequence where it stands.
        if (!SLEEP_I) begin
            case (st_r.phase)
                S_IDLE: begin
                    if (REQ_VALID_I && !mcu) begin
                        st_nxt.req.kind = REQ_KIND_I;
                        st_nxt.req.word = badr[20:1];
                        st_nxt.req.byte_address_bit = badr[0];
                        st_nxt.req.table_latch = REQ_DATA_I;
                        st_nxt.phase = S_ALE;
                    end
                end
                S_ALE: begin
                    if (st_r.req.kind == K_TABLE_WRITE_INSTR) begin
                        st_nxt.phase = S_WR;
                        st_nxt.cnt = 3'(WR_CYC - 1);
                    end else begin
                        st_nxt.phase = S_RD;
                        st_nxt.cnt = 3'(RD_CYC - 1);
                    end
                end
                S_RD: begin
                    if (st_r.cnt != 3'h0) begin
                        st_nxt.cnt = st_r.cnt - 3'h1;
                    end else if (!wide) begin
                        if (st_r.s2[7:0] == st_r.s3[7:0]) begin
                            st_nxt.rdata[7:0] = st_r.s3[7:0];
                        end
                        if (st_r.req.kind == K_FETCH) begin
                            st_nxt.phase = S_RD2;
                            st_nxt.cnt = 3'(RD_CYC - 1);
                        end else begin
                            fin = 1'b1;
                        end
                    end else begin
                        if (st_r.s2 == st_r.s3) begin
                            st_nxt.rdata = st_r.s3;
                        end
                        fin = 1'b1;
                    end
                end
                S_RD2: begin
                    if (st_r.cnt != 3'h0) begin
                        st_nxt.cnt = st_r.cnt - 3'h1;
                    end else begin
                        if (st_r.s2[7:0] == st_r.s3[7:0]) begin
                            st_nxt.rdata[15:8] = st_r.s3[7:0];
                        end
                        fin = 1'b1;
                    end
                end
                S_WR: begin
                    if (st_r.cnt != 3'h0) begin
                        st_nxt.cnt = st_r.cnt - 3'h1;
                    end else begin
                        if (!st_r.req.byte_address_bit) begin
                            st_nxt.hold = st_r.req.table_latch;
                        end
                        fin = 1'b1;
                    end
                end
                S_WAIT: begin
                    if (st_r.cnt != 3'h0) begin
                        st_nxt.cnt = st_r.cnt - 3'h1;
                    end else begin
                        st_nxt.phase = S_IDLE;
                        st_nxt.done = 1'b1;
                    end
                end
                default: begin
                    st_nxt.phase = S_IDLE;
                end
            endcase
        end

        // Table operations are stretched, fetches never are.
        if (fin) begin
            if (st_r.req.kind != K_FETCH && WAIT_EN_I && waits != 2'h0) begin
                st_nxt.phase = S_WAIT;
                st_nxt.cnt = 3'(int'(waits) * TCY_CYC - 1);
            end else begin
                st_nxt.phase = S_IDLE;
                st_nxt.done = 1'b1;
            end
        end

        // Bus levels for the phase that the next cycle shows.
        is_rd = (st_nxt.phase == S_RD) || (st_nxt.phase == S_RD2)
            || (st_nxt.phase == S_WAIT && st_nxt.req.kind != K_TABLE_WRITE_INSTR);
        is_wr = (st_nxt.phase == S_WR)
            || (st_nxt.phase == S_WAIT && st_nxt.req.kind == K_TABLE_WRITE_INSTR);
        if (st_nxt.phase != S_IDLE) begin
            ba = st_nxt.req.word[19:16];
            ba_oe = 1'b1;
            bj[J_CE] = 1'b0;
        end
        if (st_nxt.phase == S_ALE) begin
            bad = st_nxt.req.word[15:0];
            bad_oe = 1'b1;
            bj[J_ALE] = 1'b1;
        end
        if (is_rd) begin
            bj[J_OE] = 1'b0;
            if (!wide) begin
                bj[J_BA0] = (st_nxt.phase == S_RD2)
                    || (st_nxt.req.kind != K_FETCH
                        && st_nxt.req.byte_address_bit);
            end else begin
                bj[J_BA0] = st_nxt.req.kind != K_FETCH
                    && st_nxt.req.byte_address_bit;
                bj[J_LB] = 1'b0;
                bj[J_UB] = 1'b0;
            end
        end
        if (is_wr) begin
            bad = {2{st_nxt.req.table_latch}};
            bad_oe = 1'b1;
            bj[J_BA0] = st_nxt.req.byte_address_bit;
            if (!wide) begin
                bj[J_WRL] = 1'b0;
            end else if (st_nxt.ctl.write_mode_field[1]) begin
                // Word write pairs an even byte held here with the odd one.
                bad = {st_nxt.req.table_latch, st_nxt.hold};
                bad_oe = st_nxt.req.byte_address_bit;
                bj[J_WRH] = !st_nxt.req.byte_address_bit;
                bj[J_UB] = !st_nxt.req.byte_address_bit;
                bj[J_LB] = !st_nxt.req.byte_address_bit;
            end else if (st_nxt.ctl.write_mode_field == WM_BYTE_SELECT) begin
                bj[J_WRH] = 1'b0;
                bj[J_UB] = !st_nxt.req.byte_address_bit;
                bj[J_LB] = st_nxt.req.byte_address_bit;
            end else begin
                bj[J_WRH] = !st_nxt.req.byte_address_bit;
                bj[J_WRL] = st_nxt.req.byte_address_bit;
            end
        end
        if (SLEEP_I) begin
            bj[J_CE] = 1'b1;
            bj[J_LB] = 1'b1;
            bj[J_UB] = 1'b1;
        end

        // Ownership follows width and mode; the rest stays with ports.
        act = !mcu && (st_nxt.phase != S_IDLE || !st_nxt.release_eff);
        own_e = (ADDR_WIDTH_SEL_I == ABW_12) ? 8'h0f : 8'hff;
        st_nxt.own = '0;
        if (act) begin
            st_nxt.own[PIN_D_LSB +: 8] = 8'hff;
            st_nxt.own[PIN_E_LSB +: 8] = own_e;
            st_nxt.own[PIN_H_LSB +: 4] = {4{ADDR_WIDTH_SEL_I == ABW_20}};
            st_nxt.own[PIN_J_LSB +: 8] = 8'hff;
        end
        bus_o = {bj, ba, bad};
        bus_oe = {8'hff, {4{ba_oe}}, {16{bad_oe}}};
        // The bus wins over any port or peripheral on an owned pin.
        st_nxt.pin_out = (st_nxt.own & bus_o) | (~st_nxt.own & PORT_OUT_I);
        st_nxt.pin_oe = (st_nxt.own & bus_oe) | (~st_nxt.own & PORT_OE_I);
    end

    // ****************************************************************
    // Registers
    // ****************************************************************

    // Reset returns every field, the pull-up enables among them, to zero.
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            st_r <= EMB_ST_RESET;
            ctl_rd_r <= 8'h00;
            busy_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            busy_r <= (st_nxt.phase != S_IDLE);
            ctl_rd_r <= {st_nxt.ctl.bus_release, 1'b0,
                st_nxt.ctl.wait_field, 2'h0, st_nxt.ctl.write_mode_field};
        end
    end

    // Outputs come straight from the state, control readback and busy registers.
    assign PIN_OUT_O = st_r.pin_out;
    assign PIN_OE_O = st_r.pin_oe;
    assign BUS_OWN_O = st_r.own;
    assign PORT_D_PULLUP_EN_O = st_r.pad[2];
    assign PORT_E_PULLUP_EN_O = st_r.pad[1];
    assign PORT_J_PULLUP_EN_O = st_r.pad[0];
    assign CTL_RD_O = ctl_rd_r;
    assign BUSY_O = busy_r;
    assign DONE_O = st_r.done;
    assign RDATA_O = st_r.rdata;

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_mcu_no_own: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        (ADDR_WIDTH_SEL_I == ABW_MCU) |=> (BUS_OWN_O == 28'h0))
        else $error("Bus owns pins in microcontroller mode.");
    chk_ctl_frozen: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        (ADDR_WIDTH_SEL_I == ABW_MCU && CTL_WR_I) |=> $stable(CTL_RD_O))
        else $error("Control register changed in microcontroller mode.");
    chk_pullup_reset: assert property (
        @(posedge CLOCK_I)
        RST_I |=> (!PORT_D_PULLUP_EN_O && !PORT_E_PULLUP_EN_O
            && !PORT_J_PULLUP_EN_O))
        else $error("Pull-ups enabled after reset.");
    chk_idle_levels: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        (st_r.phase == S_IDLE && BUS_OWN_O[PIN_J_LSB])
        |-> (PIN_OUT_O[PIN_J_LSB +: 8] == J_IDLE
            && PIN_OE_O[PIN_D_LSB +: 8] == 8'h00))
        else $error("Idle bus pins at wrong levels.");
    chk_ale_then_oe: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        (st_r.phase == S_ALE && st_r.req.kind != K_TABLE_WRITE_INSTR && !SLEEP_I
            && BUS_OWN_O[PIN_J_LSB + J_ALE] && PIN_OUT_O[PIN_J_LSB + J_ALE])
        |=> !PIN_OUT_O[PIN_J_LSB + J_OE] && !PIN_OUT_O[PIN_J_LSB + J_ALE])
        else $error("Output enable did not follow address strobe.");
    chk_release_defer: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        (st_r.ctl.bus_release && !st_r.release_eff && !EXEC_INTERNAL_I)
        |=> !st_r.release_eff)
        else $error("Release took effect while running outside.");
    chk_wait_length: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        (st_r.phase == S_WR && st_r.cnt == 3'h0 && WAIT_EN_I
            && st_r.ctl.wait_field == 2'h0 && !SLEEP_I)
        ##1 !SLEEP_I [*3]
        |-> (st_r.phase == S_WAIT && st_r.cnt == 3'h0) ##1 DONE_O)
        else $error("Wait delay length wrong.");
    chk_byte_strobe: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        (st_r.phase == S_WR && DATA_WIDTH_SEL_I && !SLEEP_I
            && st_r.ctl.write_mode_field == WM_BYTE_WRITE
            && BUS_OWN_O[PIN_J_LSB])
        |-> (PIN_OUT_O[PIN_J_LSB + J_WRH] == !st_r.req.byte_address_bit
            && PIN_OUT_O[PIN_J_LSB + J_WRL] == st_r.req.byte_address_bit
            && PIN_OUT_O[15:8] == PIN_OUT_O[7:0]))
        else $error("Byte write strobe does not follow pointer bit.");
    chk_ce_access: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        (st_r.phase != S_IDLE && BUS_OWN_O[PIN_J_LSB] && !$past(SLEEP_I))
        |-> !PIN_OUT_O[PIN_J_LSB + J_CE])
        else $error("Chip select not active during access.");

endmodule : emb_bus

/* File: verif/emb_mem_model.sv */
// Purpose: Behavioural word memory on the multiplexed bus pins.
// Assumes: Pin layout of emb_pkg; it sees the resolved AD levels.
// Notes:   Read data is the inverse of the latched word address.
`timescale 1ns/1ps
module emb_mem_model
    import emb_pkg::*;
(
    // Bus side.
    input wire logic clk_i,
    input wire logic wide_i,
    input wire logic [27:0] pin_i,
    // Read drive and observed writes.
    output logic [15:0] drv_o,
    output logic drv_en_o,
    output logic [19:0] word_o,
    output logic [15:0] wdata_o,
    output logic wr_hi_o,
    output logic wr_lo_o
);
    // ****************
    // Memory
    // ****************
    logic [7:0] j;
    logic [15:0] rd;
    assign j = pin_i[PIN_J_LSB+:8];
    assign rd = ~word_o[15:0];
    // A byte-wide part picks its byte with the byte bit alone.
    assign drv_en_o = !j[J_OE] && !j[J_CE];
    assign drv_o = wide_i ? rd : {8'h00, j[J_BA0] ? rd[15:8] : rd[7:0]};
    // Address is latched on the strobe; each write strobe is recorded.
    always_ff @(posedge clk_i) begin
        if (j[J_ALE]) begin
            word_o <= pin_i[19:0];
            wr_hi_o <= 1'b0;
            wr_lo_o <= 1'b0;
        end
        if (!j[J_WRH] || !j[J_WRL]) begin
            wr_hi_o <= !j[J_WRH];
            wr_lo_o <= !j[J_WRL];
            wdata_o <= pin_i[15:0];
        end
    end
endmodule : emb_mem_model

/* File: verif/emb_bus_tb.sv */
// Purpose: Self-checking bench of the external memory bus pin control.
// Assumes: Default on-chip size; the memory model answers on the pins.
// Notes:   Straps are changed only while the bus is idle.
`timescale 1ns/1ps
module emb_bus_tb;
    import emb_pkg::*;
    // ****************
    // Wiring
    // ****************
    logic clk = 1'b0, rst = 1'b1, dw = 1'b1, ofs = 1'b0, wen = 1'b1;
    logic intl = 1'b1, ctl_wr = 1'b0, pad_wr = 1'b0, rv = 1'b0;
    logic [1:0] aw = ABW_20;
    logic [7:0] wd = 8'h00, ctl_rd, bj;
    emb_kind_t rk = K_FETCH;
    logic [20:0] ra = '0;
    logic [27:0] pout, poe, own, bown;
    logic [15:0] ad, ad_last = '0, mdrv, rdata, wdata;
    logic pu_d, pu_e, pu_j, men, busy, done, hi, lo;
    logic [19:0] mword;
    int fails = 0, comparisons = 0, ncyc;
    emb_bus dut_u (.CLOCK_I(clk), .RST_I(rst), .ADDR_WIDTH_SEL_I(aw),
        .DATA_WIDTH_SEL_I(dw), .ADDRESS_OFFSET_ENABLE_I(ofs),
        .WAIT_EN_I(wen), .EXEC_INTERNAL_I(intl), .SLEEP_I(1'b0),
        .CTL_WR_I(ctl_wr), .CTL_DATA_I(wd), .PAD_WR_I(pad_wr),
        .PAD_DATA_I(wd), .REQ_VALID_I(rv), .REQ_KIND_I(rk), .REQ_ADDR_I(ra),
        .REQ_DATA_I(wd), .PORT_OUT_I(28'h5a5a5a5), .PORT_OE_I(28'hfffffff),
        .PIN_AD_I(ad), .PIN_OUT_O(pout), .PIN_OE_O(poe), .BUS_OWN_O(own),
        .PORT_D_PULLUP_EN_O(pu_d), .PORT_E_PULLUP_EN_O(pu_e),
        .PORT_J_PULLUP_EN_O(pu_j), .CTL_RD_O(ctl_rd), .BUSY_O(busy),
        .DONE_O(done), .RDATA_O(rdata));
    emb_mem_model mem_u (.clk_i(clk), .wide_i(dw), .pin_i({pout[27:16], ad}),
        .drv_o(mdrv), .drv_en_o(men), .word_o(mword), .wdata_o(wdata),
        .wr_hi_o(hi), .wr_lo_o(lo));
    // Released lines take the memory drive or the pull-up, else they toggle so no stale value.
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (poe[i]) ad[i] = pout[i];
            else if (men) ad[i] = mdrv[i];
            else if (i < 8 ? pu_d : pu_e) ad[i] = 1'b1;
            else ad[i] = ~ad_last[i];
        end
    end
    always_ff @(posedge clk) ad_last <= ad;
    initial begin
        forever #5 clk = ~clk;
    end
    // ****************
    // Tasks
    // ****************
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict
    task automatic err(string m);
        fails++;
        $display("Error at %0t: %s", $time, m);
    endtask : err
    function automatic bit bad(bit c);
        comparisons++;
        return c;
    endfunction : bad
    // One control or pad write; outputs are settled when it returns.
    task automatic put(bit pad, logic [7:0] d);
        @(posedge clk);
        ctl_wr <= !pad;
        pad_wr <= pad;
        wd <= d;
        @(posedge clk);
        ctl_wr <= 1'b0;
        pad_wr <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask : put
    // One request; ncyc counts cycles from the take to the done pulse.
    task automatic access(emb_kind_t k, logic [20:0] a, logic [7:0] d);
        @(posedge clk);
        rv <= 1'b1;
        rk <= k;
        ra <= a;
        wd <= d;
        @(posedge clk);
        rv <= 1'b0;
        #1;
        bown = own;
        bj = pout[27:20];
        if (bad(busy !== 1'b1 || bj[J_CE] !== 1'b0))
            err("access not started");
        for (ncyc = 1; ncyc < 40; ncyc++) begin
            if (done === 1'b1) break;
            @(posedge clk);
            #1;
        end
        if (ncyc == 40) begin
            err("access never completed");
            print_verdict();
        end
    endtask : access
    task automatic s_pullups();
        #1;
        if (bad({pu_d, pu_e, pu_j, ctl_rd} !== 11'h0)) err("not clear");
        put(1'b1, 8'h40);
        if (bad({pu_d, pu_e, pu_j} !== 3'b010)) err("pull-up order");
        put(1'b1, 8'he0);
        if (bad({pu_d, pu_e, pu_j} !== 3'b111)) err("pull-ups off");
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        #1;
        if (bad({pu_d, pu_e, pu_j} !== 3'b000)) err("pull-ups kept");
    endtask : s_pullups
    task automatic s_idle();
        // Pins leave their reset levels one edge after reset is released.
        @(posedge clk);
        #1;
        if (bad(pout[27:20] !== J_IDLE)) err("idle control");
        if (bad(poe[19:0] !== 20'h0 || own[19:0] !== 20'hfffff))
            err("idle address lines");
        @(posedge clk);
        aw <= ABW_16;
        repeat (2) @(posedge clk);
        #1;
        if (bad(own[19:16] !== 4'h0 || pout[19:16] !== 4'h5))
            err("upper lines not ports");
        @(posedge clk);
        aw <= ABW_20;
    endtask : s_idle
    task automatic s_fetch();
        access(K_FETCH, 21'h012346, 8'h00);
        if (bad(mword !== 20'h091a3 || bj[J_CE] !== 1'b0))
            err("fetch address");
        if (bad(rdata !== 16'h6e5c)) err("fetch data");
        @(posedge clk);
        ofs <= 1'b1;
        access(K_FETCH, 21'h020008, 8'h00);
        if (bad(mword !== 20'h00004)) err("offset address");
        @(posedge clk);
        ofs <= 1'b0;
    endtask : s_fetch
    task automatic s_wait();
        int base;
        put(1'b0, 8'h30);
        access(K_TBLRD, 21'h000010, 8'h00);
        base = ncyc;
        for (int f = 0; f < 3; f++) begin
            put(1'b0, {2'b00, f[1:0], 4'h0});
            access(K_TBLRD, 21'h000010, 8'h00);
            if (bad(ncyc - base != 3 - f)) err("wait count");
        end
        @(posedge clk);
        wen <= 1'b0;
        access(K_TBLRD, 21'h000010, 8'h00);
        if (bad(ncyc != base)) err("wait while disabled");
        @(posedge clk);
        wen <= 1'b1;
    endtask : s_wait
    task automatic s_write();
        logic [7:0] cm [5] = '{8'h00, 8'h30, 8'h31, 8'h32, 8'h32};
        logic [1:0] sl [5] = '{2'b10, 2'b01, 2'b10, 2'b00, 2'b10};
        logic lb [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
        logic [7:0] dd;
        logic [15:0] ex;
        for (int i = 0; i < 5; i++) begin
            dd = 8'h10 + 8'(i);
            ex = (i == 4) ? 16'h1413 : {dd, dd};
            put(1'b0, cm[i]);
            access(K_TABLE_WRITE_INSTR, {20'h00040, lb[i]}, dd);
            if (bad({hi, lo} !== sl[i])) err("strobe");
            if (i != 3 && bad(wdata !== ex)) err("data lanes");
        end
    endtask : s_write
    task automatic s_narrow();
        @(posedge clk);
        dw <= 1'b0;
        access(K_FETCH, 21'h000246, 8'h00);
        if (bad(rdata !== 16'hfedc)) err("narrow fetch");
        @(posedge clk);
        dw <= 1'b1;
    endtask : s_narrow
    task automatic s_release();
        put(1'b0, 8'hff);
        if (bad(ctl_rd !== 8'hb3 || own[7:0] !== 8'h00))
            err("release to ports");
        access(K_FETCH, 21'h000400, 8'h00);
        if (bad(bown[27:20] !== 8'hff)) err("no bus");
        @(posedge clk);
        intl <= 1'b0;
        put(1'b0, 8'h30);
        put(1'b0, 8'hb0);
        if (bad(own[7:0] !== 8'hff)) err("early switchover");
        @(posedge clk);
        intl <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        if (bad(own[7:0] !== 8'h00)) err("late switchover");
    endtask : s_release
    task automatic s_mcu();
        @(posedge clk);
        aw <= ABW_MCU;
        put(1'b0, 8'h00);
        if (bad(ctl_rd !== 8'hb0 || own !== 28'h0)) err("bus active");
        if (bad(pout !== 28'h5a5a5a5)) err("ports lost");
    endtask : s_mcu
    // Main sequence.
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        s_pullups();
        s_idle();
        s_fetch();
        s_wait();
        s_write();
        s_narrow();
        s_release();
        s_mcu();
        print_verdict();
    end
endmodule : emb_bus_tb
